/* File: disk_track_controller.sv */
// Behaviour
// - sectors move only as whole 2048-parcel blocks
// - 48 sectors per track, chained within one command
// - sector s on spindle 4*drive + s mod 4, slot s/4
// - up to eight spindles, two logical drives routed
// - control functions go only to selected drive
// - drive status relayed to upstream control unit
// - track buffer holds data of all four spindles
// - write appends computed correction code to data
// - read checks code, corrects single-bit errors
// - write inserts 16-byte zero field at defect
// - read drops 16-byte zero field at defect
// - format records defect parameter in ID field
// - exactly one of two drive ports active
// - alternate path serves all drives when primary down
`timescale 1ns/10ps
module fifo_buf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk,     // clock
  input  wire logic             rst_n,    // sync reset
  input  wire logic             inValid,  // source offers word
  input  wire logic [WIDTH-1:0] inData,   // word in
  output logic                  inReady,  // room for a word
  output logic                  outValid, // word available
  output logic [WIDTH-1:0]      outData,  // oldest word
  input  wire logic             outReady  // sink takes word
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outValid = cnt_q != '0;
  assign outData  = mem[rp_q];
  assign cnt_d    = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wp_q] <= inData;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wp_q    <= '0;
      rp_q    <= '0;
      cnt_q   <= '0;
      inReady <= 1'b1;
    end else begin
      wp_q    <= wp_q + AW'(push);
      rp_q    <= rp_q + AW'(pop);
      cnt_q   <= cnt_d;
      inReady <= cnt_d != (AW+1)'(DEPTH);
    end
  end
endmodule

module disk_track_controller import disk_pkg::*; #(
  parameter int PARCELS = PARCELS_PER_SECTOR,
  parameter int SECTORS = SECTORS_PER_TRACK,
  parameter int FDEPTH  = FIFO_DEPTH
) (
  input  wire logic            mclk,        // 20 MHz clock
  input  wire logic            rst_n,       // sync reset
  input  wire logic            primaryUp,   // primary path in service
  input  wire logic            cmdValid,    // command offered
  input  wire cmd_t            cmd,         // command
  output logic                 cmdReady,    // idle, takes command
  input  wire logic            ctlValid,    // control function strobe
  input  wire logic [CTLW-1:0] ctlFunc,     // control function
  output logic                 dskCtlValid, // function to drives
  output logic [CTLW-1:0]      dskCtlFunc,  // forwarded function
  output logic [SPINDLES_MAX-1:0] dskCtlSel, // spindles addressed
  input  wire logic            dskStatValid, // drive status strobe
  input  wire logic [SPW-1:0]  dskStatSrc,  // reporting spindle
  input  wire logic [CTLW-1:0] dskStat,     // drive status code
  output logic                 upStatValid, // status strobe upstream
  output status_t              upStat,      // status upstream
  input  wire logic            wrValid,     // write parcel offered
  input  wire logic [PW-1:0]   wrData,      // write parcel
  output logic                 wrReady,     // write parcel taken
  output logic                 rdValid,     // read parcel offered
  output logic [PW-1:0]        rdData,      // read parcel
  input  wire logic            rdReady,     // read parcel taken
  output logic [1:0]           dskPortEn,   // active drive port
  output target_t              dskTarget,   // spindle and slot
  output logic                 dskWrValid,  // parcel to spindle
  output logic [PW-1:0]        dskWrData,   // parcel to spindle
  output logic                 dskRdEn,     // spindle may send
  input  wire logic            dskRdValid,  // parcel from spindle
  input  wire logic [PW-1:0]   dskRdData,   // parcel from spindle
  input  wire defect_t         dskDefect,   // ID-field defect of target
  output logic                 dskIdWrite,  // ID field write strobe
  output defect_t              dskIdDefect  // defect for ID field
);
  localparam int AW  = $clog2(SECTORS * PARCELS);
  localparam int ZCW = $clog2(ZERO_PARCELS + 1);
  if (SECTORS % SPINDLES_PER_DRIVE != 0 || SECTORS >= (1 << SECW) ||
      PARCELS > (1 << OFFW) || PARCELS <= ZERO_PARCELS ||
      FDEPTH < 2) begin : g_chk
    $error("unsupported track geometry");
  end

  // --------------------
  // State and buffer
  // --------------------
  state_t            state_q;
  logic              start_q;
  logic              cmdReady_q;
  logic [SECW-1:0]   sec_q;
  logic [SECW-1:0]   left_q;
  logic [SECW:0]     endSec_q;
  logic [IDXW-1:0]   idx_q;
  logic [ZCW-1:0]    zcnt_q;
  logic              ecnt_q;
  defect_t           flaw_q;
  logic              drive_q;
  logic [PW-1:0]     eX_q;
  logic [IDXW-1:0]   eI_q;
  logic [PW-1:0]     rX_q;
  logic [IDXW-1:0]   rI_q;
  logic              ownPend_q;
  logic [CTLW-1:0]   ownCode_q;
  logic [PW-1:0]     trackBuf [SECTORS*PARCELS];
  logic              fOutValid;
  logic              fOutReady;
  logic [PW-1:0]     fOutData;
  logic              skipZero;
  logic              dataDone;
  logic [AW-1:0]     curAddr;
  logic [AW-1:0]     fixAddr;
  logic              fifoTake;
  logic              rdStep;
  logic              wrEnd;
  logic              fmtTake;
  logic              lastSec;
  logic [PW-1:0]     synX;
  logic [IDXW-1:0]   synI;
  logic              fixCorr;
  logic              fixBad;
  logic              cmdTake;
  logic              cmdOk;
  logic              bufWe;
  logic [AW-1:0]     bufWa;
  logic [PW-1:0]     bufWd;
  logic [CTLW-1:0]   ownEv;
  logic              sendOwn;
  logic [SPINDLES_MAX-1:0] selMask;
  target_t           tgtNow;

  function automatic logic [AW-1:0] addrOf(input logic [SECW-1:0] s,
                                           input logic [IDXW-1:0] i);
    return AW'(s) * AW'(PARCELS) + AW'(i);
  endfunction

  // Host write path; a busy spindle transfer stalls the source
  fifo_buf #(.WIDTH(PW), .DEPTH(FDEPTH)) u_wfifo (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .inValid (wrValid),
    .inData  (wrData),
    .inReady (wrReady),
    .outValid(fOutValid),
    .outData (fOutData),
    .outReady(fOutReady)
  );
  assign fOutReady = state_q == S_FILL || state_q == S_FMT;
  assign cmdReady  = cmdReady_q;
  assign sendOwn   = !dskStatValid && ownPend_q;
  assign selMask   = SPINDLES_MAX'({SPINDLES_PER_DRIVE{1'b1}})
                     << (int'(drive_q) * SPINDLES_PER_DRIVE);

  always_comb begin
    skipZero = flaw_q.flawed && idx_q == IDXW'(flaw_q.offset) &&
               zcnt_q < ZCW'(ZERO_PARCELS);
    dataDone = idx_q == IDXW'(PARCELS);
    curAddr  = addrOf(sec_q, idx_q);
    tgtNow   = '{spindle: SPW'(int'(drive_q) * SPINDLES_PER_DRIVE +
                           int'(sec_q) % SPINDLES_PER_DRIVE),
                 slot: SLOTW'(int'(sec_q) / SPINDLES_PER_DRIVE)};
    fifoTake = fOutValid && fOutReady;
    rdStep   = state_q == S_RDISK && !start_q && dskRdValid;
    wrEnd    = state_q == S_WDISK && !start_q && !skipZero && dataDone && ecnt_q;
    fmtTake  = state_q == S_FMT && fifoTake;
    lastSec  = left_q == SECW'(1);
    synX     = eX_q ^ rX_q;
    synI     = eI_q ^ rI_q;
    fixAddr  = addrOf(sec_q, synI - 1'b1);
    // A single flipped bit shows its column in synX and its parcel in synI
    fixCorr  = state_q == S_FIX && $onehot(synX) && synI != '0 &&
               synI <= IDXW'(PARCELS);
    fixBad   = state_q == S_FIX && !fixCorr && (synX != '0 || synI != '0);
    cmdTake  = cmdValid && cmdReady_q;
    cmdOk    = (cmd.altPath ? !primaryUp : primaryUp) && cmd.op != OP_NONE &&
               cmd.count != '0 &&
               (SECW+1)'(cmd.first) + (SECW+1)'(cmd.count) <= (SECW+1)'(SECTORS);
    bufWe = 1'b0;
    bufWa = curAddr;
    bufWd = fOutData;
    if (state_q == S_FILL && fifoTake) begin
      bufWe = 1'b1;
    end else if (rdStep && !skipZero && !dataDone) begin
      bufWe = 1'b1;
      bufWd = dskRdData;
    end else if (fixCorr) begin
      bufWe = 1'b1;
      bufWa = fixAddr;
      bufWd = trackBuf[fixAddr] ^ synX;
    end
    ownEv = '0;
    if ((wrEnd || fmtTake || (state_q == S_HOST && dataDone && (!rdValid || rdReady)))
        && lastSec) begin
      ownEv = ownEv | ST_DONE;
    end
    if (fixCorr) begin
      ownEv = ownEv | ST_CORRECTED;
    end
    if (fixBad) begin
      ownEv = ownEv | ST_UNCORR;
    end
    if (cmdTake && !cmdOk) begin
      ownEv = ownEv | ST_REFUSED;
    end
  end

  always_ff @(posedge mclk) begin
    if (bufWe) begin
      trackBuf[bufWa] <= bufWd;
    end
  end

  // --------------------
  // Sequencer
  // --------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q    <= S_IDLE;
      start_q    <= 1'b0;
      cmdReady_q <= 1'b1;
      sec_q      <= '0;
      left_q     <= '0;
      endSec_q   <= '0;
      idx_q      <= '0;
      zcnt_q     <= '0;
      ecnt_q     <= 1'b0;
      flaw_q     <= '0;
      drive_q    <= 1'b0;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (cmdTake && cmdOk) begin
            cmdReady_q <= 1'b0;
            sec_q      <= cmd.first;
            left_q     <= cmd.count;
            endSec_q   <= (SECW+1)'(cmd.first) + (SECW+1)'(cmd.count);
            drive_q    <= cmd.drive;
            idx_q      <= '0;
            start_q    <= 1'b1;
            if (cmd.op == OP_READ) begin
              state_q <= S_RDISK;
            end else if (cmd.op == OP_WRITE) begin
              state_q <= S_FILL;
            end else begin
              state_q <= S_FMT;
            end
          end
        end
        S_FILL: begin
          if (fifoTake) begin
            idx_q <= idx_q + 1'b1;
            if (idx_q == IDXW'(PARCELS - 1)) begin
              idx_q   <= '0;
              state_q <= S_WDISK;
              start_q <= 1'b1;
            end
          end
        end
        S_WDISK, S_RDISK: begin
          // The target output lags the sector by a cycle; its ID field is
          // only trusted once the registered target names this sector
          if (start_q) begin
            if (dskTarget == tgtNow) begin
              start_q <= 1'b0;
              flaw_q  <= dskDefect;
            end
            zcnt_q  <= '0;
            ecnt_q  <= 1'b0;
          end else if (state_q == S_WDISK || dskRdValid) begin
            if (skipZero) begin
              zcnt_q <= zcnt_q + 1'b1;
            end else if (!dataDone) begin
              idx_q <= idx_q + 1'b1;
            end else if (!ecnt_q) begin
              ecnt_q <= 1'b1;
            end else if (state_q == S_RDISK) begin
              state_q <= S_FIX;
            end else begin
              sec_q      <= sec_q + 1'b1;
              left_q     <= left_q - 1'b1;
              idx_q      <= '0;
              state_q    <= lastSec ? S_IDLE : S_FILL;
              cmdReady_q <= lastSec;
            end
          end
        end
        S_FIX: begin
          idx_q   <= '0;
          state_q <= S_HOST;
        end
        S_HOST: begin
          if (!rdValid || rdReady) begin
            if (!dataDone) begin
              idx_q <= idx_q + 1'b1;
            end else begin
              sec_q      <= sec_q + 1'b1;
              left_q     <= left_q - 1'b1;
              idx_q      <= '0;
              start_q    <= !lastSec;
              state_q    <= lastSec ? S_IDLE : S_RDISK;
              cmdReady_q <= lastSec;
            end
          end
        end
        S_FMT: begin
          if (fifoTake) begin
            sec_q  <= sec_q + 1'b1;
            left_q <= left_q - 1'b1;
            if (lastSec) begin
              state_q    <= S_IDLE;
              cmdReady_q <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // --------------------
  // Correction code
  // --------------------
  always_ff @(posedge mclk) begin
    if (!rst_n || wrEnd || state_q == S_FIX || cmdTake) begin
      eX_q <= '0;
      eI_q <= '0;
    end else if (bufWe) begin
      eX_q <= eX_q ^ bufWd;
      eI_q <= eI_q ^ ((^bufWd) ? idx_q + 1'b1 : '0);
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rX_q <= '0;
      rI_q <= '0;
    end else if (rdStep && !skipZero && dataDone) begin
      if (!ecnt_q) begin
        rX_q <= dskRdData;
      end else begin
        rI_q <= IDXW'(dskRdData);
      end
    end
  end

  // --------------------
  // Drive side outputs
  // --------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dskWrValid  <= 1'b0;
      dskWrData   <= '0;
      dskRdEn     <= 1'b0;
      dskTarget   <= '0;
      dskPortEn   <= PORT_A;
      dskIdWrite  <= 1'b0;
      dskIdDefect <= '0;
    end else begin
      dskWrValid <= state_q == S_WDISK && !start_q;
      if (skipZero) begin
        dskWrData <= '0;
      end else if (!dataDone) begin
        dskWrData <= trackBuf[curAddr];
      end else begin
        dskWrData <= ecnt_q ? PW'(eI_q) : eX_q;
      end
      dskRdEn   <= state_q == S_RDISK && !start_q;
      dskTarget <= tgtNow;
      if (cmdTake && cmdOk) begin
        dskPortEn <= cmd.port ? PORT_B : PORT_A;
      end
      dskIdWrite <= fmtTake;
      if (fmtTake) begin
        dskIdDefect <= '{flawed: fOutData[FLAW_BIT], offset: fOutData[OFFW-1:0]};
      end
    end
  end

  // --------------------
  // Host side outputs and control forwarding
  // --------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdValid <= 1'b0;
      rdData  <= '0;
    end else if (state_q == S_HOST && (!rdValid || rdReady)) begin
      rdValid <= !dataDone;
      if (!dataDone) begin
        rdData <= trackBuf[curAddr];
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dskCtlValid <= 1'b0;
      dskCtlFunc  <= '0;
      dskCtlSel   <= '0;
    end else begin
      dskCtlValid <= ctlValid;
      dskCtlSel   <= ctlValid ? selMask : '0;
      if (ctlValid) begin
        dskCtlFunc <= ctlFunc;
      end
    end
  end
  // Drive status goes first; own events wait in a sticky pending code
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      upStatValid <= 1'b0;
      upStat      <= '0;
      ownPend_q   <= 1'b0;
      ownCode_q   <= '0;
    end else begin
      upStatValid <= dskStatValid || ownPend_q;
      if (dskStatValid) begin
        upStat <= '{fromCtrl: 1'b0, source: dskStatSrc, code: dskStat};
      end else if (ownPend_q) begin
        upStat <= '{fromCtrl: 1'b1, source: '0, code: ownCode_q};
      end
      if (ownEv != '0) begin
        ownPend_q <= 1'b1;
        ownCode_q <= sendOwn ? ownEv : (ownCode_q | ownEv);
      end else if (sendOwn) begin
        ownPend_q <= 1'b0;
        ownCode_q <= '0;
      end
    end
  end

  // --------------------
  // Checks
  // --------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_block_whole: assert property (wrEnd |-> dataDone && dskWrValid)
    else $error("sector written before full block");
  chk_chain_span: assert property (state_q != S_IDLE |->
    (SECW+1)'(sec_q) + (SECW+1)'(left_q) == endSec_q)
    else $error("chain position lost");
  chk_spread_slot: assert property (state_q != S_IDLE |=>
    dskTarget.slot == SLOTW'(int'($past(sec_q)) / SPINDLES_PER_DRIVE))
    else $error("wrong spindle slot");
  chk_ctl_select: assert property (ctlValid |=> dskCtlValid &&
    dskCtlSel == $past(selMask) && $countones(dskCtlSel) == SPINDLES_PER_DRIVE)
    else $error("function sent to wrong spindles");
  chk_stat_relay: assert property (dskStatValid |=> upStatValid &&
    !upStat.fromCtrl && upStat.code == $past(dskStat))
    else $error("drive status not relayed");
  chk_zero_write: assert property (state_q == S_WDISK && !start_q && skipZero
    |=> dskWrValid && dskWrData == '0)
    else $error("zero field not written");
  chk_zero_skip: assert property (rdStep && skipZero |-> !bufWe)
    else $error("zero field stored");
  chk_ecc_store: assert property (wrEnd |=> dskWrData == PW'($past(eI_q)))
    else $error("code parcel wrong");
  chk_fix_apply: assert property (fixCorr |=> state_q == S_HOST &&
    trackBuf[$past(fixAddr)] == ($past(trackBuf[fixAddr]) ^ $past(synX)))
    else $error("correction not applied");
  chk_uncorr_flag: assert property (fixBad |=> ownPend_q &&
    (ownCode_q & ST_UNCORR) != '0)
    else $error("uncorrectable error not reported");
  chk_alt_path: assert property (cmdTake && cmd.altPath == primaryUp
    |=> cmdReady && state_q == S_IDLE && ownPend_q)
    else $error("command taken on wrong path");
  chk_one_port: assert property ($onehot(dskPortEn))
    else $error("port enables not one-hot");
  chk_fmt_id: assert property (fmtTake |=> dskIdWrite &&
    dskIdDefect.flawed == $past(fOutData[FLAW_BIT]))
    else $error("defect parameter not recorded");
  cov_write_done: cover property (wrEnd && lastSec);
  cov_corrected: cover property (fixCorr);
  cov_read_skip: cover property (rdStep && skipZero);
  cov_backpress: cover property (wrValid && !wrReady);
endmodule

/* File: disk_pkg.sv */
package disk_pkg;
  // --------------------
  // Geometry and buffering
  // --------------------
  localparam int PARCELS_PER_SECTOR = 2048;
  localparam int SECTORS_PER_TRACK  = 48;
  localparam int SPINDLES_PER_DRIVE = 4;
  localparam int SPINDLES_MAX       = 8;
  localparam int ZERO_FIELD_BYTES   = 16;
  localparam int BYTES_PER_PARCEL   = 2;
  localparam int ZERO_PARCELS       = ZERO_FIELD_BYTES / BYTES_PER_PARCEL;
  localparam int FIFO_DEPTH         = 16;
  // --------------------
  // Field widths
  // --------------------
  localparam int PW       = 16;
  localparam int SECW     = 6;
  localparam int OFFW     = 11;
  localparam int IDXW     = 12;
  localparam int SLOTW    = 4;
  localparam int SPW      = 3;
  localparam int CTLW     = 8;
  localparam int FLAW_BIT = 15;
  // --------------------
  // Status codes, port enables
  // --------------------
  localparam logic [CTLW-1:0] ST_DONE      = 8'h01;
  localparam logic [CTLW-1:0] ST_CORRECTED = 8'h02;
  localparam logic [CTLW-1:0] ST_UNCORR    = 8'h04;
  localparam logic [CTLW-1:0] ST_REFUSED   = 8'h08;
  localparam logic [1:0]      PORT_A       = 2'h1;
  localparam logic [1:0]      PORT_B       = 2'h2;

  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_FORMAT, OP_NONE} op_t;
  typedef enum {S_IDLE, S_FILL, S_WDISK, S_RDISK, S_FIX, S_HOST, S_FMT} state_t;
  typedef struct packed {
    op_t             op;
    logic            drive;
    logic            port;
    logic            altPath;
    logic [SECW-1:0] first;
    logic [SECW-1:0] count;
  } cmd_t;
  typedef struct packed {logic flawed; logic [OFFW-1:0] offset;} defect_t;
  typedef struct packed {logic [SPW-1:0] spindle; logic [SLOTW-1:0] slot;} target_t;
  typedef struct packed {
    logic            fromCtrl;
    logic [SPW-1:0]  source;
    logic [CTLW-1:0] code;
  } status_t;
endpackage

/* File: disk_spindle_model.sv */
`timescale 1ns/10ps
module disk_spindle_model import disk_pkg::*; #(
  parameter int P = 16
) (
  input  wire logic          mclk,        // clock
  input  wire target_t       dskTarget,   // spindle and slot
  input  wire logic          dskWrValid,  // parcel to store
  input  wire logic [PW-1:0] dskWrData,   // parcel to store
  input  wire logic          dskRdEn,     // may send
  output logic               dskRdValid,  // parcel sent
  output logic [PW-1:0]      dskRdData,   // parcel sent
  output defect_t            dskDefect,   // ID-field defect
  input  wire logic          dskIdWrite,  // ID field write
  input  wire defect_t       dskIdDefect, // defect to record
  input  wire logic [PW-1:0] flipMask,    // error on parcel 0
  input  wire logic          slow         // gaps between parcels
);
  // --------------------
  // Media image
  // --------------------
  localparam int L = P + ZERO_PARCELS + 2;
  logic [PW-1:0] mem [128][L];
  int            len [128];
  defect_t       defTab [128];
  int            wIdx = 0;
  int            rIdx = 0;
  logic          gate = 1'b0;
  target_t       tgtQ = '0;
  initial begin
    dskRdValid = 1'b0;
    dskRdData = 16'h0000;
    for (int k = 0; k < 128; k++) begin
      defTab[k] = '0;
      len[k] = 0;
    end
  end
  assign dskDefect = defTab[dskTarget];
  always @(posedge mclk) begin
    if (dskIdWrite) defTab[dskTarget] <= dskIdDefect;
    if (dskWrValid && wIdx < L) begin
      mem[dskTarget][wIdx] <= dskWrData;
      wIdx <= wIdx + 1;
      len[dskTarget] <= wIdx + 1;
    end else if (!dskWrValid) wIdx <= 0;
    gate <= slow ? ~gate : 1'b1;
    tgtQ <= dskTarget;
    // Replays the stored image whole, zero field included, for the controller to drop
    if (dskRdEn && gate && dskTarget == tgtQ && rIdx < len[dskTarget]) begin
      dskRdValid <= 1'b1;
      dskRdData <= mem[dskTarget][rIdx] ^ ((rIdx == 0) ? flipMask : 16'h0000);
      rIdx <= rIdx + 1;
    end else begin
      // Idle lines never hold the last value
      dskRdValid <= 1'b0;
      dskRdData <= ~dskRdData;
      if (!dskRdEn || dskTarget != tgtQ) rIdx <= 0;
    end
  end
endmodule

/* File: tb_top.sv */
`timescale 1ns/10ps
module tb_top import disk_pkg::*; ;
  // --------------------
  // Signals
  // --------------------
  localparam int P = 16;
  logic                    mclk = 1'b0;
  logic                    rst_n = 1'b0;
  logic                    primaryUp = 1'b1;
  logic                    cmdValid = 1'b0;
  logic                    ctlValid = 1'b0;
  logic                    dskStatValid = 1'b0;
  logic                    wrValid = 1'b0;
  logic                    rdReady = 1'b0;
  logic                    slow = 1'b0;
  logic                    stClr = 1'b0;
  logic                    cmdReady, dskCtlValid, upStatValid, wrReady, rdValid;
  logic                    dskWrValid, dskRdEn, dskRdValid, dskIdWrite;
  cmd_t                    cmd = '0;
  logic [CTLW-1:0]         ctlFunc = 8'h00;
  logic [CTLW-1:0]         dskStat = 8'h00;
  logic [CTLW-1:0]         stAcc = 8'h00;
  logic [CTLW-1:0]         dskCtlFunc;
  logic [SPW-1:0]          dskStatSrc = 3'h0;
  logic [SPINDLES_MAX-1:0] dskCtlSel;
  logic [PW-1:0]           wrData = 16'h0000;
  logic [PW-1:0]           flipMask = 16'h0000;
  logic [PW-1:0]           rdData, dskWrData, dskRdData, x;
  logic [1:0]              dskPortEn;
  status_t                 upStat;
  target_t                 dskTarget, idTgt;
  defect_t                 dskDefect, dskIdDefect, idDef;
  int                      n_mismatch = 0;
  int                      checked = 0;

  disk_track_controller #(.PARCELS(P)) u_disk_track_controller (.*);
  disk_spindle_model #(.P(P)) u_disk_spindle_model (.*);

  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    if (stClr) stAcc <= 8'h00;
    else if (upStatValid && upStat.fromCtrl) stAcc <= stAcc | upStat.code;
    if (dskIdWrite) begin
      idTgt <= dskTarget;
      idDef <= dskIdDefect;
    end
  end
  // --------------------
  // Helpers
  // --------------------
  task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [15:0] pat(input int s, input int i);
    return 16'(s * 256 + i * 3 + 1);
  endfunction
  function automatic cmd_t mk(input op_t o, input int d, input int p, input int a,
                              input int f, input int c);
    return '{op: o, drive: 1'(d), port: 1'(p), altPath: 1'(a), first: 6'(f), count: 6'(c)};
  endfunction
  task send(input cmd_t c);
    stClr = 1'b1;
    cmd = c;
    cmdValid = 1'b1;
    while (cmdReady !== 1'b1) @(negedge mclk);
    @(negedge mclk);
    cmdValid = 1'b0;
    stClr = 1'b0;
  endtask
  task waitDone(input logic [7:0] exp);
    while (cmdReady !== 1'b1) @(negedge mclk);
    repeat (4) @(negedge mclk);
    check("status", 16'(stAcc), 16'(exp));
  endtask
  task put(input logic [15:0] d);
    wrValid = 1'b1;
    wrData = d;
    while (wrReady !== 1'b1) @(negedge mclk);
    @(negedge mclk);
  endtask
  task hostRead(input int s0, input int cnt, input logic [15:0] flip);
    int n;
    n = 0;
    while (n < cnt * P) begin
      rdReady = slow ? ~rdReady : 1'b1;
      if (rdValid === 1'b1 && rdReady) begin
        check("rdData", rdData, pat(s0 + n / P, n % P) ^ ((n % P == 0) ? flip : 16'h0));
        n++;
      end
      @(negedge mclk);
    end
    rdReady = 1'b0;
  endtask
  // --------------------
  // Scenarios
  // --------------------
  task t_ctl(input logic [7:0] mask);
    ctlFunc = 8'h5a;
    ctlValid = 1'b1;
    @(negedge mclk);
    ctlValid = 1'b0;
    check("ctlValid", 16'(dskCtlValid), 16'h1);
    check("ctlFunc", 16'(dskCtlFunc), 16'h5a);
    check("ctlSel", 16'(dskCtlSel), 16'(mask));
    @(negedge mclk);
    check("ctlIdle", 16'(dskCtlValid), 16'h0);
  endtask
  task t_stat;
    dskStatSrc = 3'h6;
    dskStat = 8'h40;
    dskStatValid = 1'b1;
    @(negedge mclk);
    dskStatValid = 1'b0;
    check("upStat", 16'({upStatValid, upStat}), 16'h1640);
  endtask
  task t_refuse;
    cmd_t bad [4];
    bad = '{mk(OP_READ, 0, 0, 0, 0, 0), mk(OP_READ, 0, 0, 0, 47, 2),
            mk(OP_READ, 0, 0, 1, 0, 1), mk(OP_NONE, 0, 0, 0, 0, 1)};
    foreach (bad[k]) begin
      send(bad[k]);
      repeat (4) @(negedge mclk);
      check("refused", 16'({cmdReady, stAcc}), 16'h108);
    end
  endtask
  task t_write;
    send(mk(OP_FORMAT, 1, 0, 0, 6, 1));
    put(16'h8005);
    wrValid = 1'b0;
    waitDone(ST_DONE);
    check("idTgt", 16'(idTgt), 16'h61);
    check("idDef", 16'(idDef), 16'h805);
    send(mk(OP_WRITE, 1, 0, 0, 5, 2));
    for (int s = 5; s < 7; s++) for (int i = 0; i < P; i++) put(pat(s, i));
    wrValid = 1'b0;
    waitDone(ST_DONE);
    x = 16'h0000;
    for (int i = 0; i < P; i++) x = x ^ pat(5, i);
    check("len", 16'(u_disk_spindle_model.len[7'h51]), 16'(P + 2));
    check("codeA", u_disk_spindle_model.mem[7'h51][P], x);
    check("lenFlaw", 16'(u_disk_spindle_model.len[7'h61]), 16'(P + 10));
    for (int k = 0; k < 8; k++) check("zero", u_disk_spindle_model.mem[7'h61][5 + k], 16'h0);
    check("resume", u_disk_spindle_model.mem[7'h61][13], pat(6, 5));
  endtask
  task t_read(input logic [15:0] flip, input logic sl, input logic [7:0] exp);
    flipMask = flip;
    slow = sl;
    send(mk(OP_READ, 1, 0, 0, 5, (flip == 0) ? 2 : 1));
    hostRead(5, (flip == 0) ? 2 : 1, (exp[2]) ? flip : 16'h0);
    waitDone(exp);
    flipMask = 16'h0000;
    slow = 1'b0;
  endtask
  task t_alt;
    primaryUp = 1'b0;
    send(mk(OP_FORMAT, 0, 1, 1, 0, 1));
    check("portB", 16'(dskPortEn), 16'(PORT_B));
    put(16'h0000);
    wrValid = 1'b0;
    waitDone(ST_DONE);
    primaryUp = 1'b1;
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Hang guard sized well above the few hundred cycles of traffic
  initial begin
    #2000000;
    n_mismatch++;
    finish_test;
  end
  initial begin
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    check("reset", 16'({cmdReady, wrReady, dskPortEn, dskTarget}), 16'h680);
    t_ctl(8'h0f);
    t_stat;
    t_refuse;
    t_write;
    t_ctl(8'hf0);
    t_read(16'h0000, 1'b0, ST_DONE);
    t_read(16'h0004, 1'b1, ST_DONE | ST_CORRECTED);
    t_read(16'h0003, 1'b0, ST_DONE | ST_UNCORR);
    t_alt;
    t_ctl(8'h0f);
    finish_test;
  end
endmodule
